// File: pig_defs.svh
// constants for the pixel id run generator
`ifndef PIG_DEFS_SVH
`define PIG_DEFS_SVH
`define PIG_ID_W       5
`define PIG_PAIR_W     10
`define PIG_DUR_W      11
`define PIG_XLOC_W     11
`define PIG_ENTRY_W    21
`define PIG_FIFO_DEPTH 64
`define PIG_AW         6
`define PIG_DUR_LSB    0
`define PIG_LO_LSB     11
`define PIG_HI_LSB     16
`define PIG_ONE_DUR    11'h001
`define PIG_VIS_DELAY  1
`endif

// File: pig_pkg.sv
// types for the pixel id run generator
package pig_pkg;
  typedef enum logic [1:0] {
    PIG_CONV_IDLE,
    PIG_CONV_DIFF,
    PIG_CONV_EDGE
  } pig_conv_state_t;
endpackage

// File: pig_fifo.sv
// two-port ram fifo with separate write, read and depth counters
`timescale 1ns/1ps
`include "pig_defs.svh"
module pig_fifo #(
  parameter int WIDTH = `PIG_ENTRY_W,
  parameter int DEPTH = `PIG_FIFO_DEPTH,
  parameter int AW    = `PIG_AW
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  // control
  input  wire logic             i_flush,
  input  wire logic             i_wr,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic             i_rd,
  // status and data
  output logic [WIDTH-1:0]      o_rdata,
  output logic                  o_full,
  output logic                  o_empty
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_q;
  logic [AW-1:0]    wptr_d;
  logic [AW-1:0]    rptr_q;
  logic [AW-1:0]    rptr_d;
  logic [AW:0]      depth_q;
  logic [AW:0]      depth_d;
  logic             do_wr;
  logic             do_rd;

  always_comb begin
    // full is the top depth bit, the same test that drives o_full
    do_wr   = i_wr && !depth_q[AW] && !i_flush;
    do_rd   = i_rd && (depth_q != '0) && !i_flush;
    wptr_d  = wptr_q;
    rptr_d  = rptr_q;
    depth_d = depth_q;
    if (i_flush) begin
      wptr_d  = '0;
      rptr_d  = '0;
      depth_d = '0;
    end else begin
      if (do_wr) begin
        wptr_d = wptr_q + 1'b1; // RQ3
      end
      if (do_rd) begin
        rptr_d = rptr_q + 1'b1; // RQ5
      end
      depth_d = depth_q + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end

  // RQ1
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      depth_q <= '0;
    end else begin
      wptr_q  <= wptr_d;
      rptr_q  <= rptr_d;
      depth_q <= depth_d;
    end
  end

  // ram has no reset so it maps onto a plain array
  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[wptr_q] <= i_wdata;
    end
  end

  assign o_rdata = mem[rptr_q];
  assign o_full  = depth_q[AW];
  assign o_empty = (depth_q == '0);

  property p_rq1;
    @(posedge i_clk) disable iff (!i_reset_n)
      (do_wr && !do_rd) |=> (depth_q == $past(depth_q) + 1'b1);
  endproperty
  a_rq1: assert property (p_rq1) else $error("depth did not grow on write"); // RQ1
endmodule

// File: pig_top.sv
// pixel id run generator: record converter, id fifo and pair playout
`timescale 1ns/1ps
`include "pig_defs.svh"
// Functional notes
// RQ1 - entries are kept in a 64 by 21 fifo with write, read, depth counters
// RQ2 - controller writes the next record whenever the fifo is not full; the code also needs i_enable high and no flush
// RQ3 - a loaded record gives zero to two fifo writes, each advancing write address
// RQ4 - a read entry loads the id pair register and the duration counter
// RQ5 - duration counts down each cycle; at zero the next entry is read
// RQ6 - id pair goes through extra pipeline registers before the outputs
// RQ7 - low pixel id is the low part of the pair, high pixel id the high part
// RQ8 - a record id applies from its own location to the next record location
// RQ9 - loading next registers shifts old contents to current and starts conversion
// RQ10 - each record converts in exactly two cycles into zero to two entries
// RQ11 - cycle one writes the halved difference with current id if nonzero
// RQ12 - cycle two writes duration one with current and next id if next is odd
// RQ13 - an odd next location is incremented before it becomes current
// RQ14 - equal locations after that increment give no entry
// RQ15 - durations count half rate cycles of two pixels each
// RQ16 - end of field flushes the fifo and requests end of field processing
// RQ17 - ids drive only during visible line, one cycle later than that channel; the code lags the pin three cycles
// RQ18 - refill request is raised when enabled and the fifo is not full
// RQ19 - reset clears counters, empties the fifo and drives zero ids
// RQ20 - an empty fifo at zero duration holds the outputs at zero ids
module pig_top
  import pig_pkg::*;
(
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_reset_n,
  // controller side
  input  wire logic                   i_enable,
  input  wire logic                   i_rec_load,
  input  wire logic [`PIG_XLOC_W-1:0] i_next_x_location,
  input  wire logic [`PIG_ID_W-1:0]   i_next_id_value,
  output logic                        o_refill_req,
  output logic                        o_eof_req,
  // timing channels from the pin side
  input  wire logic                   i_end_of_field_channel,
  input  wire logic                   i_visible_line_channel,
  // pixel id outputs
  output logic [`PIG_ID_W-1:0]        o_low_pixel_id,
  output logic [`PIG_ID_W-1:0]        o_high_pixel_id
);
  pig_conv_state_t              st_q;
  pig_conv_state_t              st_d;
  logic [`PIG_XLOC_W-1:0]       cur_x_q;
  logic [`PIG_XLOC_W-1:0]       cur_x_d;
  logic [`PIG_XLOC_W-1:0]       nxt_x_q;
  logic [`PIG_XLOC_W-1:0]       nxt_x_d;
  logic [`PIG_ID_W-1:0]         cur_id_q;
  logic [`PIG_ID_W-1:0]         cur_id_d;
  logic [`PIG_ID_W-1:0]         nxt_id_q;
  logic [`PIG_ID_W-1:0]         nxt_id_d;
  logic                         wr;
  logic [`PIG_ENTRY_W-1:0]      wdata;
  logic [`PIG_DUR_W-1:0]        diff;
  // synchronisers
  logic                         eof_s1_q;
  logic                         eof_s2_q;
  logic                         eof_s3_q;
  logic                         vis_s1_q;
  logic                         vis_s2_q;
  // playout
  logic [`PIG_DUR_W-1:0]        dur_q;
  logic [`PIG_DUR_W-1:0]        dur_d;
  logic [`PIG_PAIR_W-1:0]       pair_q;
  logic [`PIG_PAIR_W-1:0]       pair_d;
  logic [`PIG_PAIR_W-1:0]       pipe_q;
  logic [`PIG_PAIR_W-1:0]       pipe_d;
  logic [`PIG_PAIR_W-1:0]       out_q;
  logic [`PIG_PAIR_W-1:0]       out_d;
  logic                         refill_d;
  logic                         eof_req_d;
  logic                         refill_q;
  logic                         eof_req_q;
  logic                         rd;
  logic                         flush;
  logic                         full;
  logic                         empty;
  logic [`PIG_ENTRY_W-1:0]      rdata;

  function automatic logic [`PIG_ENTRY_W-1:0] pack_entry(input logic [`PIG_ID_W-1:0] lo,
                                                         input logic [`PIG_ID_W-1:0] hi,
                                                         input logic [`PIG_DUR_W-1:0] dur);
    pack_entry = {hi, lo, dur}; // RQ7
  endfunction

  // converter: two cycles per record
  always_comb begin
    st_d     = st_q;
    cur_x_d  = cur_x_q;
    nxt_x_d  = nxt_x_q;
    cur_id_d = cur_id_q;
    nxt_id_d = nxt_id_q;
    wr       = 1'b0;
    wdata    = '0;
    // RQ11 RQ15: halved difference counts half rate cycles
    diff     = {1'b0, nxt_x_q[10:1] - cur_x_q[10:1]};
    case (st_q)
      PIG_CONV_DIFF: begin
        wdata = pack_entry(cur_id_q, cur_id_q, diff); // RQ8
        wr    = (diff != '0); // RQ11 RQ14
        st_d  = PIG_CONV_EDGE;
      end
      PIG_CONV_EDGE: begin
        wdata = pack_entry(cur_id_q, nxt_id_q, `PIG_ONE_DUR); // RQ12
        wr    = nxt_x_q[0]; // RQ12
        if (nxt_x_q[0]) begin
          nxt_x_d = nxt_x_q + 1'b1; // RQ13
        end
        st_d  = PIG_CONV_IDLE; // RQ10
      end
      PIG_CONV_IDLE: begin
        st_d = PIG_CONV_IDLE;
      end
      default: begin
        st_d = PIG_CONV_IDLE;
      end
    endcase
    // controller only loads in idle; a load shifts next into current
    if (i_rec_load && st_q == PIG_CONV_IDLE) begin
      cur_x_d  = nxt_x_q; // RQ9
      cur_id_d = nxt_id_q;
      nxt_x_d  = i_next_x_location;
      nxt_id_d = i_next_id_value;
      st_d     = PIG_CONV_DIFF; // RQ9
    end
    if (flush) begin
      st_d = PIG_CONV_IDLE;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q     <= PIG_CONV_IDLE;
      cur_x_q  <= '0;
      nxt_x_q  <= '0;
      cur_id_q <= '0;
      nxt_id_q <= '0;
    end else begin
      st_q     <= st_d;
      cur_x_q  <= cur_x_d;
      nxt_x_q  <= nxt_x_d;
      cur_id_q <= cur_id_d;
      nxt_id_q <= nxt_id_d;
    end
  end

  pig_fifo #(
    .WIDTH(`PIG_ENTRY_W),
    .DEPTH(`PIG_FIFO_DEPTH),
    .AW   (`PIG_AW)
  ) u_fifo (
    .i_clk    (i_clk),
    .i_reset_n(i_reset_n),
    .i_flush  (flush),
    .i_wr     (wr),
    .i_wdata  (wdata),
    .i_rd     (rd),
    .o_rdata  (rdata),
    .o_full   (full),
    .o_empty  (empty)
  );

  // playout and outputs
  always_comb begin
    flush     = eof_s2_q && !eof_s3_q; // RQ16
    rd        = (dur_q == '0) && !empty; // RQ5 RQ20
    dur_d     = dur_q;
    pair_d    = pair_q;
    if (flush) begin
      dur_d  = '0;
      pair_d = '0;
    end else if (rd) begin
      dur_d  = rdata[`PIG_DUR_LSB +: `PIG_DUR_W] - 1'b1; // RQ4
      pair_d = rdata[`PIG_LO_LSB +: `PIG_PAIR_W]; // RQ4
    end else if (dur_q != '0) begin
      dur_d = dur_q - 1'b1; // RQ5
    end else begin
      pair_d = '0; // RQ20
    end
    pipe_d    = pair_q; // RQ6
    out_d     = vis_s2_q ? pipe_q : '0; // RQ17
    refill_d  = i_enable && !full && !flush; // RQ2 RQ18
    eof_req_d = flush;
  end

  // eof and visible line come off pins, so two flops before use
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      eof_s1_q  <= 1'b0;
      eof_s2_q  <= 1'b0;
      eof_s3_q  <= 1'b0;
      vis_s1_q  <= 1'b0;
      vis_s2_q  <= 1'b0;
      dur_q     <= '0; // RQ19
      pair_q    <= '0;
      pipe_q    <= '0;
      out_q     <= '0;
      refill_q  <= 1'b0;
      eof_req_q <= 1'b0;
    end else begin
      eof_s1_q  <= i_end_of_field_channel;
      eof_s2_q  <= eof_s1_q;
      eof_s3_q  <= eof_s2_q;
      vis_s1_q  <= i_visible_line_channel;
      vis_s2_q  <= vis_s1_q;
      dur_q     <= dur_d;
      pair_q    <= pair_d;
      pipe_q    <= pipe_d;
      out_q     <= out_d;
      refill_q  <= refill_d;
      eof_req_q <= eof_req_d;
    end
  end

  assign o_low_pixel_id  = out_q[`PIG_ID_W-1:0]; // RQ7
  assign o_high_pixel_id = out_q[`PIG_PAIR_W-1:`PIG_ID_W];
  assign o_refill_req    = refill_q;
  assign o_eof_req       = eof_req_q;

  property p_rq10;
    @(posedge i_clk) disable iff (!i_reset_n)
      (st_q == PIG_CONV_DIFF && !flush) |=> (st_q == PIG_CONV_EDGE);
  endproperty
  a_rq10: assert property (p_rq10) else $error("conversion not two cycles"); // RQ10

  property p_rq9;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_rec_load && st_q == PIG_CONV_IDLE && !flush) |=> (cur_x_q == $past(nxt_x_q) && st_q == PIG_CONV_DIFF);
  endproperty
  a_rq9: assert property (p_rq9) else $error("load did not shift record"); // RQ9

  property p_rq12;
    @(posedge i_clk) disable iff (!i_reset_n)
      (st_q == PIG_CONV_EDGE) |-> (wr == nxt_x_q[0]);
  endproperty
  a_rq12: assert property (p_rq12) else $error("edge write mismatch"); // RQ12

  property p_rq13;
    @(posedge i_clk) disable iff (!i_reset_n)
      (st_q == PIG_CONV_EDGE && nxt_x_q[0] && !i_rec_load) |=> !nxt_x_q[0];
  endproperty
  a_rq13: assert property (p_rq13) else $error("odd location not bumped"); // RQ13

  property p_rq11;
    @(posedge i_clk) disable iff (!i_reset_n)
      (st_q == PIG_CONV_DIFF) |-> (wr == (nxt_x_q[10:1] != cur_x_q[10:1]));
  endproperty
  a_rq11: assert property (p_rq11) else $error("diff write mismatch"); // RQ11

  property p_rq5;
    @(posedge i_clk) disable iff (!i_reset_n)
      (dur_q != '0 && !flush) |=> (dur_q == $past(dur_q) - 1'b1);
  endproperty
  a_rq5: assert property (p_rq5) else $error("duration not counting down"); // RQ5

  property p_rq17;
    @(posedge i_clk) disable iff (!i_reset_n)
      !vis_s2_q |=> (out_q == '0);
  endproperty
  a_rq17: assert property (p_rq17) else $error("ids outside visible line"); // RQ17

  property p_rq18;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_enable && !full && !flush) |=> o_refill_req;
  endproperty
  a_rq18: assert property (p_rq18) else $error("refill request missing"); // RQ18

  property p_rq6;
    @(posedge i_clk) disable iff (!i_reset_n)
      vis_s2_q |=> (out_q == $past(pair_q, 2));
  endproperty
  a_rq6: assert property (p_rq6) else $error("pipeline depth wrong"); // RQ6
endmodule

// File: pig_ctrl_model.sv
// behavioural master controller feeding transition records
`timescale 1ns/1ps
`include "pig_defs.svh"
module pig_ctrl_model (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_reset_n,
  // block side
  input  wire logic                   i_refill_req,
  output logic                        o_rec_load,
  output logic [`PIG_XLOC_W-1:0]      o_next_x_location,
  output logic [`PIG_ID_W-1:0]        o_next_id_value
);
  logic [15:0] rec_q[$];
  int          gap;
  task automatic push(input logic [10:0] x, input logic [4:0] id);
    rec_q.push_back({id, x});
  endtask
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rec_load        <= 1'b0;
      o_next_x_location <= 11'h000;
      o_next_id_value   <= 5'h00;
      gap               <= 0;
    end else if (gap == 0 && i_refill_req && rec_q.size() > 0) begin
      {o_next_id_value, o_next_x_location} <= rec_q.pop_front();
      o_rec_load <= 1'b1;
      // converter is busy for two cycles after each load
      gap <= 2 + int'($urandom % 3);
    end else begin
      o_rec_load <= 1'b0;
      // data is meaningless outside a load, so keep it moving
      o_next_x_location <= ~o_next_x_location;
      o_next_id_value   <= ~o_next_id_value;
      if (gap > 0) begin
        gap <= gap - 1;
      end
    end
  end
endmodule

// File: pig_top_tb_top.sv
// self-checking bench for the pixel id run generator
`timescale 1ns/1ps
`include "pig_defs.svh"
module pig_top_tb_top;
  logic       clk, reset_n, enable, eof_ch, vis_ch, rec_load, refill_req, eof_req;
  logic [10:0] nx;
  logic [4:0]  nid, lo, hi;
  logic [9:0]  obs_q[$];
  logic [9:0]  exp_q[$];
  int          err_total, n_compared;
  int          xs[$], ids[$];
  int          x, i;

  pig_top DUT (.i_clk(clk), .i_reset_n(reset_n), .i_enable(enable), .i_rec_load(rec_load),
    .i_next_x_location(nx), .i_next_id_value(nid), .o_refill_req(refill_req), .o_eof_req(eof_req),
    .i_end_of_field_channel(eof_ch), .i_visible_line_channel(vis_ch),
    .o_low_pixel_id(lo), .o_high_pixel_id(hi));
  pig_ctrl_model u_ctrl (.i_clk(clk), .i_reset_n(reset_n), .i_refill_req(refill_req),
    .o_rec_load(rec_load), .o_next_x_location(nx), .o_next_id_value(nid));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // zero pairs are gaps from an empty fifo, so only ids are collected
  always @(negedge clk)
    if (reset_n && {hi, lo} !== 10'h000) obs_q.push_back({hi, lo});

  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    n_compared++;
    if (seen !== want) begin
      err_total++;
      $display("BAD t=%0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_obs(input int n);
    int c;
    for (c = 0; c < 4000 && obs_q.size() < n; c++) @(posedge clk);
    if (obs_q.size() < n) begin
      err_total++;
      $display("BAD t=%0t wait ran out", $time);
      print_verdict();
    end
  endtask
  task automatic do_reset(input logic vis, input logic en);
    u_ctrl.rec_q.delete();
    @(posedge clk);
    reset_n <= 1'b0;
    tick(7);
    // look between edges, away from any launch
    @(negedge clk);
    check({refill_req, eof_req, hi, lo}, 12'h000, "reset outputs");
    @(posedge clk);
    reset_n <= 1'b1;
    enable <= en;
    vis_ch <= vis;
    eof_ch <= 1'b0;
    obs_q.delete();
  endtask
  // pixel stream from the records, folded into pairs, low pixel even
  function automatic void build_exp();
    logic [4:0] px[$];
    exp_q.delete();
    for (int k = 0; k < xs.size() - 1; k++) repeat (xs[k+1] - xs[k]) px.push_back(ids[k][4:0]);
    for (int k = 0; k < px.size(); k += 2) exp_q.push_back({px[k+1], px[k]});
  endfunction
  task automatic run_line();
    do_reset(1'b1, 1'b1);
    build_exp();
    foreach (xs[k]) u_ctrl.push(xs[k][10:0], ids[k][4:0]);
    wait_obs(exp_q.size());
    tick(20);
    check(obs_q.size(), exp_q.size(), "pair count");
    foreach (exp_q[k]) check(obs_q[k], exp_q[k], "pair");
  endtask

  initial begin
    reset_n = 1'b0;
    enable = 1'b0;
    eof_ch = 1'b0;
    vis_ch = 1'b0;
    err_total = 0;
    n_compared = 0;
    void'($urandom(30828));
    // worked example: even, odd, equal and long runs
    xs = '{0, 4, 7, 8, 1280};
    ids = '{1, 2, 3, 4, 5};
    run_line();
    repeat (3) begin
      xs = '{0};
      ids = '{1 + $urandom % 31};
      x = 0;
      for (i = 0; i < 40; i++) begin
        x += 1 + $urandom % 6;
        xs.push_back(x);
        ids.push_back(1 + $urandom % 31);
      end
      xs.push_back(x + 2 + (x % 2));
      ids.push_back(7);
      run_line();
    end
    // disabled block asks for nothing
    do_reset(1'b0, 1'b0);
    u_ctrl.push(11'h000, 5'h09);
    u_ctrl.push(11'h0c8, 5'h0a);
    u_ctrl.push(11'h190, 5'h0b);
    tick(20);
    check(refill_req, 1'b0, "refill while disabled");
    enable <= 1'b1;
    tick(40);
    check(obs_q.size(), 0, "ids outside visible line");
    vis_ch <= 1'b1;
    tick(2);
    @(negedge clk);
    check({hi, lo}, 10'h000, "visible too early");
    @(negedge clk);
    check({hi, lo}, {5'h09, 5'h09}, "visible pair");
    @(posedge clk);
    eof_ch <= 1'b1;
    for (i = 0; i < 10 && eof_req !== 1'b1; i++) @(negedge clk);
    check(eof_req, 1'b1, "end of field request");
    @(negedge clk);
    check(eof_req, 1'b0, "end of field pulse");
    tick(4);
    @(negedge clk);
    check({refill_req, hi, lo}, 11'h400, "flushed fifo");
    print_verdict();
  end
endmodule
